//--- shared/tpc_pkg.sv
// package for the timer pwm control block: register map, fields, reset values, types
// assumes a 32-bit apb slave with word-aligned registers
package tpc_pkg;
	localparam int unsigned NCH_DEF = 4;
	localparam int unsigned CNT_W_DEF = 16;
	localparam int unsigned PRESC_W = 6;

	// register byte offsets
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_CNT = 8'h04;
	localparam logic [7:0] OFS_MOD = 8'h08;
	localparam logic [7:0] OFS_CH_BASE = 8'h10;
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [2:0] OFS_CH_CTRL = 3'h0;
	localparam logic [2:0] OFS_CH_CMP = 3'h4;

	// timer_main_ctrl_reg fields
	localparam int unsigned MAIN_OVF_BIT = 7;
	localparam int unsigned MAIN_IE_BIT = 6;
	localparam int unsigned MAIN_HALT_BIT = 5;
	localparam int unsigned MAIN_CRST_BIT = 4;
	localparam int unsigned MAIN_PS_LSB = 0;
	localparam int unsigned PS_W = 3;

	// channel_ctrl_reg fields
	localparam int unsigned CH_FLAG_BIT = 7;
	localparam int unsigned CH_IE_BIT = 6;
	localparam int unsigned CH_LINK_BIT = 5;
	localparam int unsigned CH_UNBUF_BIT = 4;
	localparam int unsigned CH_ELS_LSB = 2;
	localparam int unsigned CH_TOV_BIT = 1;
	localparam int unsigned CH_MAXD_BIT = 0;

	// reset values; PS_EXT is the external clock prescaler select code
	localparam logic HALT_RST = 1'b1;
	localparam logic [15:0] MOD_RST = 16'hffff;
	localparam logic [PS_W-1:0] PS_RST = 3'h0;
	localparam logic [PS_W-1:0] PS_EXT = 3'h7;

	// compare action; for capture the same codes mean rise / fall / any edge
	typedef enum logic [1:0]
	{
		ELS_NONE   = 2'b00,
		ELS_TOGGLE = 2'b01,
		ELS_CLEAR  = 2'b10,
		ELS_SET    = 2'b11
	} tpc_els_t;

	typedef enum logic [1:0]
	{
		MODE_PRESET  = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_COMPARE = 2'b10
	} tpc_mode_t;

	typedef struct packed
	{
		logic     link;
		logic     unbuf;
		tpc_els_t els;
		logic     tov;
		logic     maxd;
	} tpc_chcfg_t;
endpackage

//--- verilog/tpc_channel.sv
// one timer channel: compare match, edge capture detect, output pin level
// assumes tick/wrap are single-cycle strobes from the counter in the parent
`timescale 1ns/1ns
module tpc_channel
#(
	parameter int unsigned CNT_W = 16
)
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire tpc_pkg::tpc_chcfg_t cfg,
	input  wire logic               tick,
	input  wire logic               wrap,
	input  wire logic [CNT_W-1:0]   cnt,
	input  wire logic [CNT_W-1:0]   cmp_val,
	input  wire logic               pin_in,
	output logic                    match_o,
	output logic                    capt_o,
	output logic                    pin_out
);
	tpc_pkg::tpc_mode_t mode;
	logic               pin_d_r;
	logic               rise;
	logic               fall;
	logic               pulse_lvl;

	always_comb
	begin
		if (cfg.els == tpc_pkg::ELS_NONE)
			mode = tpc_pkg::MODE_PRESET;
		else if (cfg.link || cfg.unbuf) // see RULE_08
			mode = tpc_pkg::MODE_COMPARE;
		else
			mode = tpc_pkg::MODE_CAPTURE;
	end

	assign rise = pin_in & ~pin_d_r;
	assign fall = ~pin_in & pin_d_r;
	// pulse level is the complement of the compare action
	assign pulse_lvl = (cfg.els != tpc_pkg::ELS_SET);
	assign match_o = (mode == tpc_pkg::MODE_COMPARE) && tick && (cnt == cmp_val); // see RULE_12
	assign capt_o = (mode == tpc_pkg::MODE_CAPTURE) &&
		((cfg.els[0] && rise) || (cfg.els[1] && fall)); // see RULE_12

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_d_r <= 1'b0;
		else
			pin_d_r <= pin_in;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_out <= 1'b0;
		else
		begin
			unique case (mode)
				tpc_pkg::MODE_PRESET:
					pin_out <= ~cfg.unbuf;
				tpc_pkg::MODE_CAPTURE:
					pin_out <= pin_out;
				tpc_pkg::MODE_COMPARE:
				begin
					if (cfg.maxd)
						pin_out <= pulse_lvl; // see RULE_10
					else if (match_o)
					begin
						// end of pulse; see RULE_23
						unique case (cfg.els)
							tpc_pkg::ELS_TOGGLE: pin_out <= ~pin_out;
							tpc_pkg::ELS_CLEAR:  pin_out <= 1'b0;
							tpc_pkg::ELS_SET:    pin_out <= 1'b1;
							default:             pin_out <= pin_out;
						endcase
					end
					else if (wrap && cfg.tov)
						pin_out <= ~pin_out; // see RULE_09
				end
				default:
					pin_out <= pin_out;
			endcase
		end
	end
endmodule

//--- verilog/tpc_timer.sv
// timer pwm control top: apb registers, prescaler, counter, four channels, flags
// assumes apb master on clk; break, stop and external clock inputs synchronous to clk
//
// Operation
// RULE_01 - software halts, clears, programs, then releases
// RULE_02 - mode bits 0:1 unbuffered, 1:0 buffered
// RULE_03 - pwm compare action clears or sets output
// RULE_04 - software sets toggle-on-wrap for pwm
// RULE_05 - software avoids toggle-on-compare for pwm
// RULE_06 - buffered widths go to inactive set
// RULE_07 - link bit pairs channels; lower one governs
// RULE_08 - link bit overrides unbuffered mode bit
// RULE_09 - no toggle on wrap gives 0% duty
// RULE_10 - full duty bit holds output at pulse level
// RULE_11 - overflow flag at modulo; gated interrupt request
// RULE_12 - channel flag on capture/compare; gated request
// RULE_13 - wait mode keeps timer running and waking
// RULE_14 - stop mode freezes counter, keeps state
// RULE_15 - debug break holds counter halted
// RULE_16 - break clears status only with break clear
// RULE_17 - armed clear survives break, completes afterwards
// RULE_18 - prescaler select all ones picks external clock
// RULE_19 - overflow flag cleared by read-then-write-zero
// RULE_20 - halt bit freezes counter; reset sets it
// RULE_21 - counter reset bit clears counter, reads zero
// RULE_22 - software keeps halt clear before wait
// RULE_23 - width is wrap to match; period wrap-to-wrap
// RULE_24 - counter restarts from zero after modulo
// RULE_25 - requests follow flag and enable
`timescale 1ns/1ns
module tpc_timer
#(
	parameter int unsigned NCH   = tpc_pkg::NCH_DEF,
	parameter int unsigned CNT_W = tpc_pkg::CNT_W_DEF
)
(
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           dbg_break,
	input  wire logic           break_clear_enable,
	input  wire logic           stop_mode,
	input  wire logic           external_count_clock,
	input  wire logic [NCH-1:0] ch_pin_in,
	output logic [NCH-1:0]      ch_pin_out,
	output logic                ovf_irq,
	output logic [NCH-1:0]      ch_irq
);
	localparam int unsigned NPAIR = NCH / 2;

	generate
		if (NCH != 4)
			$error("tpc_timer: NCH must be 4");
		if (CNT_W < 2 || CNT_W > 16)
			$error("tpc_timer: CNT_W must be 2..16");
	endgenerate

	logic [CNT_W-1:0]           cnt_r;
	logic [CNT_W-1:0]           mod_r;
	logic [tpc_pkg::PRESC_W-1:0] presc_r;
	logic [tpc_pkg::PS_W-1:0]   ps_r;
	logic                       halt_r;
	logic                       ovf_ie_r;
	logic                       ovf_flag_r;
	logic                       ovf_arm_r;
	logic                       ext_d_r;
	tpc_pkg::tpc_chcfg_t        chcfg_r [NCH];
	logic [NCH-1:0]             ch_ie_r;
	logic [NCH-1:0]             ch_flag_r;
	logic [NCH-1:0]             ch_arm_r;
	logic [CNT_W-1:0]           cmp_r [NCH];
	logic [NPAIR-1:0]           last_up_r;
	logic [NPAIR-1:0]           act_up_r;
	logic [31:0]                rdata_nxt;

	logic                       acc;
	logic                       wr_en;
	logic                       rd_en;
	logic                       hit_main;
	logic                       hit_cnt;
	logic                       hit_mod;
	logic                       hit_ch;
	logic                       mapped;
	logic [7:0]                 ch_off;
	logic [1:0]                 ch_idx;
	logic                       ch_is_cmp;
	logic                       prot;
	logic                       run;
	logic                       ext_rise;
	logic [tpc_pkg::PRESC_W-1:0] ps_mask;
	logic                       div_tick;
	logic                       tick;
	logic                       wrap;
	logic                       crst;
	logic                       ovf_clr;
	logic [NCH-1:0]             ch_match;
	logic [NCH-1:0]             ch_capt;
	logic [NCH-1:0]             ch_evt;

	// apb decode; a transfer completes at the edge where pready is high
	assign acc = psel & penable & pready;
	assign wr_en = acc & pwrite;
	assign rd_en = acc & ~pwrite;
	assign hit_main = (paddr == tpc_pkg::OFS_MAIN);
	assign hit_cnt = (paddr == tpc_pkg::OFS_CNT);
	assign hit_mod = (paddr == tpc_pkg::OFS_MOD);
	assign ch_off = paddr - tpc_pkg::OFS_CH_BASE;
	assign ch_idx = ch_off[4:3];
	assign ch_is_cmp = (ch_off[2:0] == tpc_pkg::OFS_CH_CMP);
	assign hit_ch = (paddr >= tpc_pkg::OFS_CH_BASE) &&
		(ch_off < 8'(NCH * tpc_pkg::CH_STRIDE)) &&
		(ch_is_cmp || ch_off[2:0] == tpc_pkg::OFS_CH_CTRL);
	assign mapped = hit_main | hit_cnt | hit_mod | hit_ch;

	// status bits protected while in break without break clear
	assign prot = dbg_break & ~break_clear_enable; // see RULE_16

	// counting: halted by halt bit, debug break and stop; wait mode does not gate
	assign run = ~halt_r & ~dbg_break & ~stop_mode; // see RULE_13 see RULE_14 see RULE_15 see RULE_20
	assign ext_rise = external_count_clock & ~ext_d_r;
	assign ps_mask = tpc_pkg::PRESC_W'((7'h01 << ps_r) - 7'h01);
	assign div_tick = ((presc_r & ps_mask) == ps_mask);
	assign tick = run & ((ps_r == tpc_pkg::PS_EXT) ? ext_rise : div_tick); // see RULE_18
	assign wrap = tick & (cnt_r == mod_r); // see RULE_11 see RULE_23
	assign crst = wr_en & hit_main & pwdata[tpc_pkg::MAIN_CRST_BIT];
	assign ovf_clr = wr_en & hit_main & ~pwdata[tpc_pkg::MAIN_OVF_BIT] & ovf_arm_r & ~prot;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pready <= 1'b0;
		else
			pready <= psel & penable & ~pready;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && penable && !pready)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
			pslverr <= ~mapped;
		end
		else
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit_main)
		begin
			rdata_nxt[tpc_pkg::MAIN_OVF_BIT] = ovf_flag_r;
			rdata_nxt[tpc_pkg::MAIN_IE_BIT] = ovf_ie_r;
			rdata_nxt[tpc_pkg::MAIN_HALT_BIT] = halt_r;
			// counter reset bit always reads zero; see RULE_21
			rdata_nxt[tpc_pkg::MAIN_PS_LSB +: tpc_pkg::PS_W] = ps_r;
		end
		else if (hit_cnt)
			rdata_nxt[CNT_W-1:0] = cnt_r;
		else if (hit_mod)
			rdata_nxt[CNT_W-1:0] = mod_r;
		else if (hit_ch && ch_is_cmp)
			rdata_nxt[CNT_W-1:0] = cmp_r[ch_idx];
		else if (hit_ch)
		begin
			rdata_nxt[tpc_pkg::CH_FLAG_BIT] = ch_flag_r[ch_idx];
			rdata_nxt[tpc_pkg::CH_IE_BIT] = ch_ie_r[ch_idx];
			rdata_nxt[tpc_pkg::CH_MAXD_BIT +: 6] = chcfg_r[ch_idx];
		end
	end

	// main control fields and modulo register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			halt_r <= tpc_pkg::HALT_RST; // see RULE_20
			ovf_ie_r <= 1'b0;
			ps_r <= tpc_pkg::PS_RST;
			mod_r <= tpc_pkg::MOD_RST[CNT_W-1:0];
		end
		else if (wr_en && hit_main)
		begin
			halt_r <= pwdata[tpc_pkg::MAIN_HALT_BIT];
			ovf_ie_r <= pwdata[tpc_pkg::MAIN_IE_BIT];
			ps_r <= pwdata[tpc_pkg::MAIN_PS_LSB +: tpc_pkg::PS_W];
		end
		else if (wr_en && hit_mod)
			mod_r <= pwdata[CNT_W-1:0];
	end

	// prescaler and counter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ext_d_r <= 1'b0;
		else
			ext_d_r <= external_count_clock;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			presc_r <= '0;
		else if (crst)
			presc_r <= '0; // see RULE_21
		else if (run)
			presc_r <= presc_r + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_r <= '0;
		else if (crst)
			cnt_r <= '0; // see RULE_21
		else if (wrap)
			cnt_r <= '0; // see RULE_24
		else if (tick)
			cnt_r <= cnt_r + 1'b1;
	end

	// overflow flag with read-then-write-zero clear; a new wrap wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ovf_flag_r <= 1'b0;
		else if (wrap)
			ovf_flag_r <= 1'b1; // see RULE_11
		else if (ovf_clr)
			ovf_flag_r <= 1'b0; // see RULE_19
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ovf_arm_r <= 1'b0;
		else if (wrap)
			ovf_arm_r <= 1'b0; // see RULE_19
		else if (rd_en && hit_main && prdata[tpc_pkg::MAIN_OVF_BIT] && !prot)
			ovf_arm_r <= 1'b1; // arm only on the value the read returned
		else if (wr_en && hit_main && !prot)
			ovf_arm_r <= 1'b0; // see RULE_17
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ovf_irq <= 1'b0;
		else
			ovf_irq <= ovf_flag_r & ovf_ie_r; // see RULE_11 see RULE_25
	end

	// buffered pairs: the set written last takes over at the next wrap
	genvar p;
	generate
		for (p = 0; p < NPAIR; p++)
		begin : g_pair
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					last_up_r[p] <= 1'b0;
					act_up_r[p] <= 1'b0;
				end
				else
				begin
					if (wr_en && hit_ch && ch_is_cmp && ch_idx[1] == 1'(p))
						last_up_r[p] <= ch_idx[0];
					if (!chcfg_r[2*p].link)
						act_up_r[p] <= 1'b0; // see RULE_07
					else if (wrap)
						act_up_r[p] <= last_up_r[p];
				end
			end
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < NCH; i++)
		begin : g_ch
			tpc_pkg::tpc_chcfg_t eff_cfg;
			logic [CNT_W-1:0]    cmp_sel;
			logic                hit_this;
			logic                clr_this;

			assign hit_this = hit_ch && (ch_idx == 2'(i));
			assign clr_this = wr_en && hit_this && !ch_is_cmp &&
				!pwdata[tpc_pkg::CH_FLAG_BIT] && ch_arm_r[i] && !prot;

			if (i % 2 == 0)
			begin : g_low
				// lower channel drives the pair from the active set; see RULE_07
				assign cmp_sel = act_up_r[i/2] ? cmp_r[i+1] : cmp_r[i];
				assign eff_cfg = chcfg_r[i];
			end
			else
			begin : g_up
				// upper channel idles while its pair is linked
				assign cmp_sel = cmp_r[i];
				assign eff_cfg = chcfg_r[i-1].link ? '0 : chcfg_r[i];
			end

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					chcfg_r[i] <= '0;
					ch_ie_r[i] <= 1'b0;
				end
				else if (wr_en && hit_this && !ch_is_cmp)
				begin
					chcfg_r[i] <= pwdata[tpc_pkg::CH_MAXD_BIT +: 6];
					if (i % 2 == 1)
						chcfg_r[i].link <= 1'b0;
					ch_ie_r[i] <= pwdata[tpc_pkg::CH_IE_BIT];
				end
			end

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					cmp_r[i] <= '0;
				else if (ch_capt[i])
					cmp_r[i] <= cnt_r;
				else if (wr_en && hit_this && ch_is_cmp)
					cmp_r[i] <= pwdata[CNT_W-1:0];
			end

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					ch_flag_r[i] <= 1'b0;
				else if (ch_evt[i])
					ch_flag_r[i] <= 1'b1; // see RULE_12
				else if (clr_this)
					ch_flag_r[i] <= 1'b0; // see RULE_16
			end

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					ch_arm_r[i] <= 1'b0;
				else if (ch_evt[i])
					ch_arm_r[i] <= 1'b0;
				else if (rd_en && hit_this && !ch_is_cmp && prdata[tpc_pkg::CH_FLAG_BIT] && !prot)
					ch_arm_r[i] <= 1'b1; // arm only on the value the read returned
				else if (wr_en && hit_this && !ch_is_cmp && !prot)
					ch_arm_r[i] <= 1'b0; // see RULE_17
			end

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					ch_irq[i] <= 1'b0;
				else
					ch_irq[i] <= ch_flag_r[i] & ch_ie_r[i]; // see RULE_12 see RULE_25
			end

			assign ch_evt[i] = ch_match[i] | ch_capt[i];

			tpc_channel
			#(
				.CNT_W (CNT_W)
			)
			u_ch
			(
				.clk     (clk),
				.rst_b   (rst_b),
				.cfg     (eff_cfg),
				.tick    (tick),
				.wrap    (wrap),
				.cnt     (cnt_r),
				.cmp_val (cmp_sel),
				.pin_in  (ch_pin_in[i]),
				.match_o (ch_match[i]),
				.capt_o  (ch_capt[i]),
				.pin_out (ch_pin_out[i])
			);
		end
	endgenerate
endmodule

//--- dv/tpc_timer_assertions.sv
// checker for tpc_timer: register read data and request outputs
// assumes binding to tpc_timer and a read data of zero outside read completions
`timescale 1ns/1ns
module tpc_timer_assertions
#(
	parameter int unsigned NCH = 4
)
(
	input wire logic           clk,
	input wire logic           rst_b,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire logic [31:0]    pwdata,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire logic [NCH-1:0] ch_pin_out,
	input wire logic           ovf_irq,
	input wire logic [NCH-1:0] ch_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence rd_at(logic [7:0] a);
		pready && !pwrite && paddr == a;
	endsequence
	a_crst_reads_zero: assert property (rd_at(8'h00) |-> !prdata[4])
		else $error("counter reset bit read back as one");
	a_ovf_irq_on: assert property (rd_at(8'h00) ##0 prdata[7] && prdata[6] |-> ##[1:2] ovf_irq)
		else $error("overflow request missing");
	a_ovf_irq_off: assert property (rd_at(8'h00) ##0 !prdata[6] |-> ##1 !ovf_irq [*2])
		else $error("overflow request while disabled");
	a_ch_irq_on: assert property (rd_at(8'h10) ##0 prdata[7] && prdata[6] |-> ##[1:2] ch_irq[0])
		else $error("channel request missing");
	a_ch_irq_off: assert property (rd_at(8'h10) ##0 !prdata[7] |-> !ch_irq[0])
		else $error("channel request without flag");
	a_link_upper_zero: assert property (rd_at(8'h18) |-> !prdata[5])
		else $error("upper channel link bit set");
	a_full_duty_hi: assert property (rd_at(8'h10) ##0 prdata[0] && prdata[3:2] == 2'b10 |-> ##1 ch_pin_out[0])
		else $error("full duty output not high");
	a_full_duty_lo: assert property (rd_at(8'h10) ##0 prdata[0] && prdata[3:2] == 2'b11 |-> ##1 !ch_pin_out[0])
		else $error("full duty output not low");
	c_ovf_irq: cover property (rd_at(8'h00) ##0 prdata[7] && prdata[6]);
	c_ch_irq: cover property (rd_at(8'h10) ##0 prdata[7] && prdata[6]);
	c_err: cover property (pready && pslverr);
endmodule
bind tpc_timer tpc_timer_assertions #(.NCH(NCH)) chk_u (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ch_pin_out(ch_pin_out), .ovf_irq(ovf_irq), .ch_irq(ch_irq));

//--- dv/tpc_timer_tb_top.sv
// self-checking bench for tpc_timer: registers, counting, flags, break, pwm output
// assumes design files and tpc_pkg compiled first; one capture input stepped high once
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %0t %h %h", $time, (g), (e)); end end
module tpc_timer_tb_top;
	logic        clk, rst_b, psel, penable, pwrite, brk, bce, stp, xclk;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, v, m, w;
	logic        pready, pslverr, ovf_irq;
	logic [3:0]  pin_out, ch_irq, pin_in;
	logic [64:0] nt;
	logic [64:0] exp_q[$];
	int          err_count, check_count;
	tpc_timer dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dbg_break(brk), .break_clear_enable(bce), .stop_mode(stp), .external_count_clock(xclk),
		.ch_pin_in(pin_in), .ch_pin_out(pin_out), .ovf_irq(ovf_irq), .ch_irq(ch_irq));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
		input logic er);
		exp_q.push_back({er, mk, e});
		apb(1'b0, a, 32'h0);
	endtask
	// high cycles of channel 0 over one period
	task automatic duty(input logic [31:0] e);
		logic [31:0] c;
		repeat (3 * (m + 1)) @(posedge clk);
		c = 0;
		repeat (m + 1)
		begin
			@(posedge clk);
			c = c + 32'(pin_out[0]);
		end
		`CHK(c, e)
	endtask
	always @(posedge clk)
		if (pready && !pwrite && exp_q.size() > 0)
		begin
			nt = exp_q.pop_front();
			`CHK({pslverr, prdata & nt[63:32]}, {nt[64], nt[31:0]})
		end
	initial
	begin
		#(40 * 40000);
		err_count++;
		finish_test();
	end
	initial
	begin
		{rst_b, psel, penable, pwrite, brk, bce, stp, xclk} = 8'h00;
		paddr = 8'h00;
		pin_in = 4'h0;
		pwdata = 32'h0;
		err_count = 0;
		check_count = 0;
		void'($urandom(21));
		m = 32'd6 + 32'($urandom % 6);
		w = 32'd1 + 32'($urandom % (m - 2));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdx(8'h00, '1, 32'h20, 1'b0);
		rdx(8'h08, '1, 32'hffff, 1'b0);
		rdx(8'h0c, '1, 32'h0, 1'b1);
		wr(8'h18, 32'h20);
		rdx(8'h18, 32'h20, 32'h0, 1'b0);
		wr(8'h08, m);
		wr(8'h00, 32'h50);
		repeat (m + 3) @(posedge clk);
		rdx(8'h00, 32'h80, 32'h80, 1'b0);
		`CHK(ovf_irq, 1'b1)
		repeat (4)
		begin
			apb(1'b0, 8'h04, 32'h0);
			`CHK(rd <= m, 1'b1)
		end
		apb(1'b0, 8'h00, 32'h0);
		repeat (m + 2) @(posedge clk);
		wr(8'h00, 32'h40);
		rdx(8'h00, 32'h80, 32'h80, 1'b0);
		wr(8'h00, 32'he0);
		rdx(8'h00, '1, 32'he0, 1'b0);
		wr(8'h00, 32'h60);
		rdx(8'h00, '1, 32'h60, 1'b0);
		`CHK(ovf_irq, 1'b0)
		wr(8'h00, 32'he0);
		rdx(8'h00, 32'h80, 32'h0, 1'b0);
		apb(1'b0, 8'h04, 32'h0);
		v = rd;
		repeat (m) @(posedge clk);
		rdx(8'h04, '1, v, 1'b0);
		wr(8'h00, 32'h30);
		rdx(8'h04, '1, 32'h0, 1'b0);
		wr(8'h00, 32'h00);
		repeat (m + 3) @(posedge clk);
		wr(8'h00, 32'h20);
		apb(1'b0, 8'h00, 32'h0);
		brk <= 1'b1;
		wr(8'h00, 32'h10);
		repeat (m) @(posedge clk);
		rdx(8'h00, 32'h80, 32'h80, 1'b0);
		rdx(8'h04, '1, 32'h0, 1'b0);
		brk <= 1'b0;
		wr(8'h00, 32'h20);
		rdx(8'h00, 32'h80, 32'h0, 1'b0);
		wr(8'h00, 32'h00);
		repeat (m + 3) @(posedge clk);
		wr(8'h00, 32'h20);
		bce <= 1'b1;
		brk <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		wr(8'h00, 32'h20);
		brk <= 1'b0;
		rdx(8'h00, 32'h80, 32'h0, 1'b0);
		stp <= 1'b1;
		wr(8'h00, 32'h10);
		repeat (m) @(posedge clk);
		rdx(8'h04, '1, 32'h0, 1'b0);
		stp <= 1'b0;
		wr(8'h00, 32'h17);
		repeat (3)
		begin
			xclk <= 1'b1;
			repeat (2) @(posedge clk);
			xclk <= 1'b0;
			repeat (2) @(posedge clk);
		end
		rdx(8'h04, '1, 32'h3, 1'b0);
		wr(8'h14, w);
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h00, 32'h30);
			wr(8'h10, i == 0 ? 32'h1a : i == 1 ? 32'h18 : i == 2 ? 32'h1b :
				i == 3 ? 32'h1e : i == 4 ? 32'h2a : 32'h3a);
			wr(8'h00, 32'h00);
			duty(i == 1 ? 32'h0 : i == 2 ? m + 1 : i == 3 ? m - w : w + 1);
			if (i == 2)
				rdx(8'h10, 32'h7f, 32'h1b, 1'b0);
		end
		wr(8'h1c, w + 1);
		duty(w + 2);
		wr(8'h10, 32'h1f);
		rdx(8'h10, 32'h7f, 32'h1f, 1'b0);
		`CHK(pin_out[0], 1'b0)
		wr(8'h10, 32'h5a);
		repeat (m + 3) @(posedge clk);
		rdx(8'h10, 32'h80, 32'h80, 1'b0);
		`CHK(ch_irq[0], 1'b1)
		wr(8'h10, 32'h1a);
		repeat (2) @(posedge clk);
		`CHK(ch_irq[0], 1'b0)
		wr(8'h20, 32'h04);
		pin_in <= 4'h4;
		repeat (2) @(posedge clk);
		rdx(8'h20, 32'h80, 32'h80, 1'b0);
		finish_test();
	end
endmodule
